// file: core/tcoc_output_ctrl.sv
// channel output latches of a multi-channel timer unit, with register port
// assumes timer counters supply one-cycle interrupt, start and count-tick pulses
`timescale 1ns/1ps
`include "tcoc_regs.svh"

module tcoc_output_ctrl #(
  parameter int NCH = 8,
  parameter int DW  = 16
) (
  input  wire logic            i_ref_clk,
  input  wire logic            i_sys_rst,
  input  wire logic [7:0]      i_addr,
  input  wire logic [DW-1:0]   i_wdata,
  input  wire logic            i_wr,
  input  wire logic            i_rd,
  output logic      [DW-1:0]   o_rdata,
  input  wire logic [NCH-1:0]  i_chan_irq,
  input  wire logic [NCH-1:0]  i_count_start,
  input  wire logic [NCH-1:0]  i_ivl_cap_mode,
  input  wire logic [NCH-1:0]  i_count_tick,
  output logic      [NCH-1:0]  o_chan_irq,
  output logic      [NCH-1:0]  o_chan_out
);

  // ------------------------------------------------------------------
  // register state
  // ------------------------------------------------------------------
  logic [NCH-1:0]          out_level_reg;
  logic [NCH-1:0]          out_level_next;
  logic [NCH-1:0]          out_enable_reg;
  logic [NCH-1:0]          out_polarity_reg;
  logic [NCH-1:0]          out_mode_reg;
  logic [NCH-1:0]          start_irq_sel_reg;
  logic [NCH-1:0]          set_pend_reg;
  logic [NCH-1:0]          set_pend_next;
  logic [NCH-1:0]          irq_eff;
  logic [NCH-1:0]          master_irq;
  logic [NCH-1:0]          set_ev;
  logic [NCH-1:0]          rst_ev;
  logic [DW-1:0]           rdata_reg;
  logic [DW-1:0]           rdata_next;
  tcoc_pkg::tcoc_reg_sel_t sel;
  logic                    lvl_wr;

  // ------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------
  // one decode shared by reads and writes keeps the map in one place
  always_comb begin
    case (i_addr)
      `TCOC_OFF_LEVEL:     sel = tcoc_pkg::TCOC_SEL_LEVEL;
      `TCOC_OFF_ENABLE:    sel = tcoc_pkg::TCOC_SEL_ENABLE;
      `TCOC_OFF_POLARITY:  sel = tcoc_pkg::TCOC_SEL_POLARITY;
      `TCOC_OFF_MODE:      sel = tcoc_pkg::TCOC_SEL_MODE;
      `TCOC_OFF_START_SEL: sel = tcoc_pkg::TCOC_SEL_START_SEL;
      default:             sel = tcoc_pkg::TCOC_SEL_NONE;
    endcase
  end

  assign lvl_wr = i_wr && (sel == tcoc_pkg::TCOC_SEL_LEVEL);

  // ------------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------------
  // none of these reach the counters; they steer the latches and the start interrupt
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      out_enable_reg    <= NCH'(`TCOC_RST_ENABLE);
      out_polarity_reg  <= NCH'(`TCOC_RST_POLARITY);
      out_mode_reg      <= NCH'(`TCOC_RST_MODE);
      start_irq_sel_reg <= NCH'(`TCOC_RST_START_SEL);
    end else if (i_wr) begin
      case (sel)
        tcoc_pkg::TCOC_SEL_ENABLE:    out_enable_reg    <= i_wdata[NCH-1:0];
        tcoc_pkg::TCOC_SEL_POLARITY:  out_polarity_reg  <= i_wdata[NCH-1:0];
        tcoc_pkg::TCOC_SEL_MODE:      out_mode_reg      <= i_wdata[NCH-1:0];
        tcoc_pkg::TCOC_SEL_START_SEL: start_irq_sel_reg <= i_wdata[NCH-1:0];
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // read path
  // ------------------------------------------------------------------
  // reads never depend on enables; unmapped addresses return zero
  always_comb begin
    rdata_next = '0;
    if (i_rd) begin
      case (sel)
        tcoc_pkg::TCOC_SEL_LEVEL:     rdata_next[NCH-1:0] = out_level_reg;
        tcoc_pkg::TCOC_SEL_ENABLE:    rdata_next[NCH-1:0] = out_enable_reg;
        tcoc_pkg::TCOC_SEL_POLARITY:  rdata_next[NCH-1:0] = out_polarity_reg;
        tcoc_pkg::TCOC_SEL_MODE:      rdata_next[NCH-1:0] = out_mode_reg;
        tcoc_pkg::TCOC_SEL_START_SEL: rdata_next[NCH-1:0] = start_irq_sel_reg;
        default:                      rdata_next = '0;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ------------------------------------------------------------------
  // per-channel event and latch logic
  // ------------------------------------------------------------------
  for (genvar c = 0; c < NCH; c++) begin : g_chan
    // master of a slave is the nearest even channel below it
    localparam int MST   = (c == 0) ? 0 : ((c - 1) / 2) * 2;
    localparam bit HAS_M = (c != 0);

    // start interrupt only in interval/capture mode with the bit set
    assign irq_eff[c] = i_chan_irq[c]
                      | (i_count_start[c] & i_ivl_cap_mode[c] & start_irq_sel_reg[c]);

    assign master_irq[c] = HAS_M ? irq_eff[MST] : 1'b0;

    // delayed master action and live polarity select the events
    assign set_ev[c] = out_polarity_reg[c] ? irq_eff[c]
                                           : (set_pend_reg[c] & i_count_tick[c]);
    assign rst_ev[c] = out_polarity_reg[c] ? (set_pend_reg[c] & i_count_tick[c])
                                           : irq_eff[c];

    // latch next value; software only reaches disabled channels
    always_comb begin
      if (!out_enable_reg[c]) begin
        // interrupts blocked, writes land
        out_level_next[c] = lvl_wr ? i_wdata[c] : out_level_reg[c];
      end else if (out_mode_reg[c] == tcoc_pkg::TCOC_MODE_MASTER) begin
        // polarity ignored, toggle on own interrupt; writes dropped
        out_level_next[c] = irq_eff[c] ? ~out_level_reg[c] : out_level_reg[c];
      end else if (rst_ev[c]) begin
        out_level_next[c] = 1'b0; // reset masks a coincident set
      end else if (set_ev[c]) begin
        out_level_next[c] = 1'b1;
      end else begin
        out_level_next[c] = out_level_reg[c];
      end
    end

    // pending master action waits for the next count tick
    always_comb begin
      if (!(out_enable_reg[c] && out_mode_reg[c])) begin
        set_pend_next[c] = 1'b0;
      end else if (master_irq[c]) begin
        set_pend_next[c] = 1'b1;
      end else if (i_count_tick[c]) begin
        set_pend_next[c] = 1'b0;
      end else begin
        set_pend_next[c] = set_pend_reg[c];
      end
    end
  end

  // ------------------------------------------------------------------
  // latch and pending registers
  // ------------------------------------------------------------------
  // latches start low so pins idle until a level is written or an enabled channel takes an event
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      out_level_reg <= NCH'(`TCOC_RST_LEVEL);
    end else begin
      out_level_reg <= out_level_next;
    end
  end

  // pending set cleared whenever the channel leaves enabled slave mode
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      set_pend_reg <= '0;
    end else begin
      set_pend_reg <= set_pend_next;
    end
  end

  // interrupts forwarded one cycle late so the output is a flip-flop
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_chan_irq <= '0;
    end else begin
      o_chan_irq <= irq_eff;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign o_chan_out = out_level_reg;
  assign o_rdata    = rdata_reg;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  // latch and interrupt checks per channel; every antecedent but AST_NO_START_IRQ reads the registered configuration
  for (genvar k = 0; k < NCH; k++) begin : g_chk
    AST_MASTER_TOGGLE: assert property (
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (out_enable_reg[k] && !out_mode_reg[k] && irq_eff[k])
        |=> (out_level_reg[k] != $past(out_level_reg[k])))
      else $error("enabled master channel did not toggle");

    AST_DISABLED_BLOCKS_IRQ: assert property (
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (!out_enable_reg[k] && !lvl_wr) |=> $stable(out_level_reg[k]))
      else $error("disabled channel changed without a write");

    AST_SW_WRITE_TAKEN: assert property (
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (!out_enable_reg[k] && lvl_wr) |=> (out_level_reg[k] == $past(i_wdata[k])))
      else $error("write to disabled channel not applied");

    AST_ENABLED_IGNORES_WRITE: assert property (
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (out_enable_reg[k] && !out_mode_reg[k] && !irq_eff[k] && lvl_wr)
        |=> $stable(out_level_reg[k]))
      else $error("enabled channel took a software write");

    AST_RESET_WINS: assert property (
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (out_enable_reg[k] && out_mode_reg[k] && rst_ev[k] && set_ev[k])
        |=> !out_level_reg[k])
      else $error("set was not masked by coincident reset");

    AST_SET_DELAYED: assert property (
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (out_enable_reg[k] && out_mode_reg[k] && !out_polarity_reg[k]
       && master_irq[k] && !set_pend_reg[k] && !irq_eff[k] && !out_level_reg[k])
        |=> !out_level_reg[k])
      else $error("master set acted without count clock delay");

    AST_NO_START_IRQ: assert property (
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_count_start[k] && !i_ivl_cap_mode[k] && !i_chan_irq[k])
        |=> !o_chan_irq[k])
      else $error("start interrupt raised outside interval or capture");

    AST_START_IRQ: assert property (
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_count_start[k] && i_ivl_cap_mode[k] && start_irq_sel_reg[k])
        |=> o_chan_irq[k])
      else $error("start interrupt missing");

    AST_POL_NO_IMMEDIATE: assert property (
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (out_enable_reg[k] && out_mode_reg[k] && !set_ev[k] && !rst_ev[k])
        |=> $stable(out_level_reg[k]))
      else $error("slave output moved without an event");

    AST_POS_SLAVE_RESET: assert property (
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (out_enable_reg[k] && out_mode_reg[k] && !out_polarity_reg[k] && irq_eff[k])
        |=> !out_level_reg[k])
      else $error("positive slave output not reset by its own interrupt");

    AST_NEG_SLAVE_SET: assert property (
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (out_enable_reg[k] && out_mode_reg[k] && out_polarity_reg[k] && irq_eff[k]
       && !(set_pend_reg[k] && i_count_tick[k]))
        |=> out_level_reg[k])
      else $error("negative slave output not set by its own interrupt");

    AST_SET_ON_TICK: assert property (
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (out_enable_reg[k] && out_mode_reg[k] && !out_polarity_reg[k]
       && set_pend_reg[k] && i_count_tick[k] && !irq_eff[k])
        |=> out_level_reg[k])
      else $error("pending master set not applied at the count tick");

    AST_PEND_DROPPED: assert property (
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      !(out_enable_reg[k] && out_mode_reg[k]) |=> !set_pend_reg[k])
      else $error("pending set kept outside enabled slave mode");

    AST_NO_STRAY_IRQ: assert property (
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (!i_chan_irq[k] && !(i_count_start[k] && start_irq_sel_reg[k])) |=> !o_chan_irq[k])
      else $error("interrupt raised without a cause");
  end

  // reset clears every pin whatever state came before, so no disable here
  AST_RESET_LOW: assert property (
    @(posedge i_ref_clk)
    i_sys_rst |=> (o_chan_out == '0))
    else $error("output latch not cleared by reset");

  AST_RDATA_IDLE: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    !i_rd |=> (o_rdata == '0))
    else $error("read data stood outside the cycle after a read");

  AST_READ_LEVEL: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_rd && sel == tcoc_pkg::TCOC_SEL_LEVEL)
      |=> (o_rdata[NCH-1:0] == $past(out_level_reg)))
    else $error("level read did not return the latches");

  COV_MASTER_TOGGLE: cover property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    out_enable_reg[0] && !out_mode_reg[0] && irq_eff[0]);

  COV_SLAVE_PWM_SET: cover property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    out_enable_reg[1] && out_mode_reg[1] && set_ev[1] && !rst_ev[1]);

  COV_ZERO_DUTY: cover property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    out_enable_reg[1] && out_mode_reg[1] && set_ev[1] && rst_ev[1]);

  COV_MASKED_WRITE: cover property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    lvl_wr && (out_enable_reg != '0) && (out_enable_reg != '1));

  COV_START_IRQ: cover property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    i_count_start[2] && i_ivl_cap_mode[2] && start_irq_sel_reg[2]);

endmodule // tcoc_output_ctrl

// file: shared/tcoc_regs.svh
// register offsets, field positions, reset values and timing counts
// guarded against repeated inclusion; plain word addresses on the register port
`ifndef TCOC_REGS_SVH
`define TCOC_REGS_SVH

// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define TCOC_OFF_LEVEL     8'h00
`define TCOC_OFF_ENABLE    8'h01
`define TCOC_OFF_POLARITY  8'h02
`define TCOC_OFF_MODE      8'h03
`define TCOC_OFF_START_SEL 8'h04

// ------------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------------
`define TCOC_CHAN_LSB      0
`define TCOC_RST_LEVEL     8'h00
`define TCOC_RST_ENABLE    8'h00
`define TCOC_RST_POLARITY  8'h00
`define TCOC_RST_MODE      8'h00
`define TCOC_RST_START_SEL 8'h00

// ------------------------------------------------------------------
// timing counts
// ------------------------------------------------------------------
`define TCOC_SET_DELAY_TICKS 1

`endif

// file: shared/tcoc_pkg.sv
// types shared by the channel output control block
// assumes the register header supplies the numeric constants
package tcoc_pkg;

  // decoded register target of a bus access
  typedef enum logic [2:0] {
    TCOC_SEL_LEVEL,
    TCOC_SEL_ENABLE,
    TCOC_SEL_POLARITY,
    TCOC_SEL_MODE,
    TCOC_SEL_START_SEL,
    TCOC_SEL_NONE
  } tcoc_reg_sel_t;

  // output mode of one channel
  typedef enum logic {
    TCOC_MODE_MASTER = 1'b0,
    TCOC_MODE_SLAVE  = 1'b1
  } tcoc_out_mode_t;

endpackage

// file: test/tcoc_counter_model.sv
// stand-in for the timer counters: count ticks, interrupt and start pulses
// assumes the bench requests one-cycle pulses, set just after a rising edge
`timescale 1ns/1ps
module tcoc_counter_model #(
  parameter int DIV = 4
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_sys_rst,
  input  wire logic [7:0] i_irq_req,
  input  wire logic [7:0] i_start_req,
  output logic      [7:0] o_chan_irq,
  output logic      [7:0] o_count_start,
  output logic      [7:0] o_count_tick
);
  logic [7:0] div_reg;

  // shared prescaler; every channel sees the same count clock phase
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || div_reg == 8'(DIV - 1))
      div_reg <= 8'h00;
    else
      div_reg <= div_reg + 8'h01;
  end
  assign o_count_tick = (div_reg == 8'(DIV - 1)) ? 8'hFF : 8'h00;

  // events pass straight through, one cycle each
  assign o_chan_irq    = i_irq_req;
  assign o_count_start = i_start_req;
endmodule // tcoc_counter_model

// file: test/tcoc_output_ctrl_test.sv
// self-checking bench for the channel output latches
// assumes counter model with DIV=4; register map from the shared header
`timescale 1ns/1ps
`include "tcoc_regs.svh"
module tcoc_output_ctrl_test;
  localparam int DIV = 4;
  logic        clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0;
  logic [7:0]  addr = 8'h00, irq_req = 8'h00, start_req = 8'h00, ivl = 8'h00;
  logic [15:0] wdata = 16'h0000, rdata;
  logic [7:0]  irq, start, tick, irq_out, chan_out;
  int          mismatches = 0, num_checks = 0;

  always #2.5 clk = ~clk;

  tcoc_counter_model #(.DIV(DIV)) u_cnt (.i_ref_clk(clk), .i_sys_rst(rst),
    .i_irq_req(irq_req), .i_start_req(start_req), .o_chan_irq(irq),
    .o_count_start(start), .o_count_tick(tick));
  tcoc_output_ctrl u_dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_chan_irq(irq),
    .i_count_start(start), .i_ivl_cap_mode(ivl), .i_count_tick(tick),
    .o_chan_irq(irq_out), .o_chan_out(chan_out));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 check(rdata, exp);
  endtask
  task automatic pulse(input logic [7:0] irq_m, input logic [7:0] st_m);
    @(posedge clk);
    irq_req   <= irq_m;
    start_req <= st_m;
    @(posedge clk);
    irq_req   <= 8'h00;
    start_req <= 8'h00;
    #1;
  endtask
  // master irq one cycle before a count tick; slave irq optionally on the tick
  task automatic slave_evt(input logic both, input logic old, input logic exp);
    do @(posedge clk); while (tick[1] !== 1'b1);
    repeat (DIV - 2) @(posedge clk);
    irq_req <= 8'h01;
    @(posedge clk);
    irq_req <= {6'h00, both, 1'b0};
    #1 check(16'(chan_out[1]), 16'(old));
    @(posedge clk);
    irq_req <= 8'h00;
    #1 check(16'(chan_out[1]), 16'(exp));
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    for (int a = 0; a < 8; a++)
      rd_chk(8'(a), 16'h0000);
    #1 check(rdata, 16'h0000);
    check(16'(chan_out), 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_master;
    wr(`TCOC_OFF_ENABLE, 16'h0001);
    wr(`TCOC_OFF_POLARITY, 16'h0001);
    pulse(8'h01, 8'h00);
    check(16'(chan_out), 16'h0001);
    check(16'(irq_out), 16'h0001);
    pulse(8'h01, 8'h00);
    check(16'(chan_out), 16'h0000);
    rd_chk(`TCOC_OFF_LEVEL, 16'h0000);
    wr(`TCOC_OFF_POLARITY, 16'h0000);
    $display("test master done");
  endtask
  task automatic t_slave;
    wr(`TCOC_OFF_MODE, 16'h0002);
    wr(`TCOC_OFF_ENABLE, 16'h0003);
    slave_evt(1'b1, 1'b0, 1'b0);
    repeat (DIV) @(posedge clk);
    #1 check(16'(chan_out[1]), 16'h0000);
    slave_evt(1'b0, 1'b0, 1'b1);
    wr(`TCOC_OFF_POLARITY, 16'h0002);
    #1 check(16'(chan_out[1]), 16'h0001);
    rd_chk(`TCOC_OFF_POLARITY, 16'h0002);
    slave_evt(1'b0, 1'b1, 1'b0);
    pulse(8'h02, 8'h00);
    check(16'(chan_out[1]), 16'h0001);
    $display("test slave done");
  endtask
  // collective write: enabled bits keep timer control
  task automatic t_enable;
    wr(`TCOC_OFF_ENABLE, 16'h0000);
    wr(`TCOC_OFF_MODE, 16'h0000);
    wr(`TCOC_OFF_POLARITY, 16'h0000);
    wr(`TCOC_OFF_LEVEL, 16'h0022);
    wr(`TCOC_OFF_ENABLE, 16'h002F);
    wr(`TCOC_OFF_LEVEL, 16'h00C3);
    #1 check(16'(chan_out), 16'h00E2);
    rd_chk(`TCOC_OFF_LEVEL, 16'h00E2);
    rd_chk(`TCOC_OFF_ENABLE, 16'h002F);
    @(posedge clk);
    #1 check(rdata, 16'h0000);
    pulse(8'h40, 8'h00);
    check(16'(chan_out), 16'h00E2);
    pulse(8'h20, 8'h00);
    check(16'(chan_out), 16'h00C2);
    $display("test enable done");
  endtask
  task automatic t_start;
    wr(`TCOC_OFF_ENABLE, 16'h0004);
    wr(`TCOC_OFF_START_SEL, 16'h0004);
    rd_chk(`TCOC_OFF_START_SEL, 16'h0004);
    ivl <= 8'h04;
    pulse(8'h00, 8'h04);
    check(16'(irq_out), 16'h0004);
    check(16'(chan_out), 16'h00C6);
    wr(`TCOC_OFF_START_SEL, 16'h0000);
    pulse(8'h00, 8'h04);
    check(16'(irq_out), 16'h0000);
    check(16'(chan_out), 16'h00C6);
    wr(`TCOC_OFF_START_SEL, 16'h0004);
    ivl <= 8'h00;
    pulse(8'h00, 8'h04);
    check(16'(irq_out), 16'h0000);
    check(16'(chan_out), 16'h00C6);
    $display("test start done");
  endtask

  // channel 3 follows channel 2, not channel 0; then a reset in mid-run
  task automatic t_pair;
    wr(`TCOC_OFF_ENABLE, 16'h0000);
    wr(`TCOC_OFF_LEVEL, 16'h0000);
    wr(`TCOC_OFF_MODE, 16'h0008);
    wr(`TCOC_OFF_ENABLE, 16'h0008);
    rd_chk(`TCOC_OFF_MODE, 16'h0008);
    pulse(8'h01, 8'h00);
    repeat (DIV) @(posedge clk);
    #1 check(16'(chan_out), 16'h0000);
    pulse(8'h04, 8'h00);
    repeat (DIV) @(posedge clk);
    #1 check(16'(chan_out), 16'h0008);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 check(16'(chan_out), 16'h0000);
    rd_chk(`TCOC_OFF_MODE, 16'h0000);
    $display("test pair done");
  endtask

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_master();
    t_slave();
    t_enable();
    t_start();
    t_pair();
    final_report();
  end
  // watchdog: whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    $display("watchdog expired at t=%0t", $time);
    final_report();
  end
endmodule // tcoc_output_ctrl_test
